// [core/fpec_core.v]
// Contract
// - Byte program only clears bits; only erase sets bits back to one.
// - Flash pages are 512 bytes; erase sets every byte of the page to ff.
// - Program and erase are timed internally; no polling needed.
// - Core execution is stalled for the whole program or erase.
// - Key register takes a5 then f1 before each operation, in order.
// - Wrong or out-of-order key blocks flash modification until reset.
// - An operation attempted before full key blocks modification until reset.
// - Key relocks after each completed program or erase.
// - Write enable steers external-move writes to flash until software clears it.
// - Erase: erase and write enable, keys, one write anywhere in the page.
// - Program: write enable, erase clear, keys, one data write programs the byte.
// - Short 8-bit-address writes above 00ff never program or erase flash; a short erase still clears its whole page.
// - Block write caches first byte, commits pair at second in one byte time.
// - In block write a lone first byte is never committed.
// - Modify only with write enable; erase needs write and erase enable.
`timescale 1ns/1ps
`include "fpec_defines.vh"

module fpec_core #(
   parameter AW          = 15,
   parameter PROG_CYCLES = ((`FPEC_PROG_TIME_US * `FPEC_CLK_MHZ) < 1) ? 1 :
                           (`FPEC_PROG_TIME_US * `FPEC_CLK_MHZ),
   parameter ERASE_CYCLES = `FPEC_ERASE_TIME_US * `FPEC_CLK_MHZ
) (
   // Clock and reset
   input  wire          i_clk,
   input  wire          i_rst,
   // AHB-Lite slave
   input  wire          i_hsel,
   input  wire [31:0]   i_haddr,
   input  wire [1:0]    i_htrans,
   input  wire          i_hwrite,
   input  wire [2:0]    i_hsize,
   input  wire [31:0]   i_hwdata,
   input  wire          i_hready,
   output wire          o_hreadyout,
   output wire          o_hresp,
   output reg  [31:0]   o_hrdata,
   // Flash array port
   output reg           o_fl_prog,
   output reg           o_fl_erase,
   output reg  [AW-1:0] o_fl_addr,
   output reg  [15:0]   o_fl_wdata,
   output reg           o_fl_pair,
   input  wire [7:0]    i_fl_rdata,
   // Data RAM port for writes that miss flash
   output reg           o_ram_we,
   output reg  [15:0]   o_ram_addr,
   output reg  [7:0]    o_ram_wdata,
   // Core stall
   output wire          o_core_stall
);

   // -------------------------------------------------------------------
   // Constants
   // -------------------------------------------------------------------
   localparam [31:0] PROG_CNT  = PROG_CYCLES;
   localparam [31:0] ERASE_CNT = ERASE_CYCLES;
   localparam [31:0] PAGE_MASK = `FPEC_PAGE_BYTES - 1;

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_PROG = 2'h1;
   localparam [1:0] ST_ERAS = 2'h2;

   localparam [1:0] KEY_LOCKED = 2'h0;
   localparam [1:0] KEY_HALF   = 2'h1;
   localparam [1:0] KEY_OPEN   = 2'h2;

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   reg  [1:0]    ctrl_r;
   reg  [7:0]    scale_r;
   reg  [7:0]    cache_ctl_r;
   reg  [1:0]    key_r;
   reg           blocked_r;
   reg  [1:0]    state_r;
   reg  [31:0]   cnt_r;
   reg           buf_vld_r;
   reg  [AW-1:0] buf_addr_r;
   reg  [7:0]    buf_data_r;
   reg  [16:0]   xaddr_r;
   reg           dph_r;
   reg           dwr_r;
   reg  [11:0]   doff_r;

   wire          busy   = (state_r != ST_IDLE);
   wire          wr_en  = ctrl_r[`FPEC_CTRL_WE_BIT];
   wire          er_en  = ctrl_r[`FPEC_CTRL_EE_BIT];
   wire          blk_en = cache_ctl_r[`FPEC_CACHE_BLK_BIT];
   wire [15:0]   xa     = xaddr_r[15:0];
   wire          xshort = xaddr_r[`FPEC_XADDR_SHORT_BIT];

   // Stall a bus data phase that falls in an operation; the core itself is held off by o_core_stall
   assign o_hreadyout  = ~(dph_r & busy);
   assign o_core_stall = busy;
   assign o_hresp      = 1'b0;

   wire addr_ph = i_hsel & i_hready & i_htrans[1];

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function [AW-1:0] page_base;
      input [AW-1:0] a;
      begin
         page_base = a & ~PAGE_MASK[AW-1:0];
      end
   endfunction

   // -------------------------------------------------------------------
   // Address phase capture
   // -------------------------------------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         dph_r  <= 1'b0;
         dwr_r  <= 1'b0;
         doff_r <= 12'h000;
      end else if (o_hreadyout) begin
         dph_r  <= addr_ph;
         dwr_r  <= addr_ph & i_hwrite;
         doff_r <= i_haddr[11:0];
      end
   end

   wire wr_go = dph_r & dwr_r & ~busy;

   // -------------------------------------------------------------------
   // Read mux
   // -------------------------------------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hrdata <= 32'h00000000;
      end else if (addr_ph & ~i_hwrite & o_hreadyout) begin
         case (i_haddr[11:0])
            `FPEC_OFF_CTRL:   o_hrdata <= {30'h0, ctrl_r};
            `FPEC_OFF_SCALE:  o_hrdata <= {24'h0, scale_r};
            `FPEC_OFF_CACHE:  o_hrdata <= {24'h0, cache_ctl_r};
            `FPEC_OFF_STATUS: o_hrdata <= {27'h0, buf_vld_r, blocked_r, busy, key_r};
            `FPEC_OFF_XADDR:  o_hrdata <= {15'h0, xaddr_r};
            `FPEC_OFF_XDATA:  o_hrdata <= {24'h0, i_fl_rdata};
            default:          o_hrdata <= 32'h00000000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Registers, key machine and operation sequencer
   // -------------------------------------------------------------------
   wire          xwr      = wr_go & (doff_r == `FPEC_OFF_XDATA);
   wire          to_flash = xwr & wr_en;
   wire          short_ok = ~xshort | (xa <= `FPEC_SHORT_ADDR_MAX);
   wire [7:0]    xd       = i_hwdata[7:0];
   wire [AW-1:0] fa       = xa[AW-1:0];

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_r      <= `FPEC_CTRL_RST;
         scale_r     <= `FPEC_SCALE_RST;
         cache_ctl_r <= `FPEC_CACHE_RST;
         key_r       <= KEY_LOCKED;
         blocked_r   <= 1'b0;
         state_r     <= ST_IDLE;
         cnt_r       <= 32'h00000000;
         buf_vld_r   <= 1'b0;
         buf_addr_r  <= {AW{1'b0}};
         buf_data_r  <= 8'h00;
         xaddr_r     <= 17'h00000;
         o_fl_prog   <= 1'b0;
         o_fl_erase  <= 1'b0;
         o_fl_addr   <= {AW{1'b0}};
         o_fl_wdata  <= 16'h0000;
         o_fl_pair   <= 1'b0;
         o_ram_we    <= 1'b0;
         o_ram_addr  <= 16'h0000;
         o_ram_wdata <= 8'h00;
      end else begin
         o_fl_prog  <= 1'b0;
         o_fl_erase <= 1'b0;
         o_ram_we   <= 1'b0;
         if (busy) begin
            // Hardware timing of the operation
            if (cnt_r <= 32'h00000001) begin
               state_r <= ST_IDLE;
               cnt_r   <= 32'h00000000;
            end else begin
               cnt_r <= cnt_r - 32'h00000001;
            end
         end
         if (wr_go) begin
            case (doff_r)
               `FPEC_OFF_CTRL:  ctrl_r      <= i_hwdata[1:0];
               `FPEC_OFF_SCALE: scale_r     <= i_hwdata[7:0];
               `FPEC_OFF_CACHE: cache_ctl_r <= i_hwdata[7:0];
               `FPEC_OFF_XADDR: xaddr_r     <= i_hwdata[16:0];
               `FPEC_OFF_KEY: begin
                  // Blocking does not stop the key sequence; blocked_r still bars flash until reset
                  if (key_r == KEY_LOCKED && xd == `FPEC_KEY_FIRST)
                     key_r <= KEY_HALF;
                  else if (key_r == KEY_HALF && xd == `FPEC_KEY_SECOND)
                     key_r <= KEY_OPEN;
                  else begin
                     key_r     <= KEY_LOCKED;
                     blocked_r <= 1'b1;
                  end
               end
               default: ;
            endcase
         end
         if (xwr & ~wr_en) begin
            // RAM write leaves flash and key alone
            o_ram_we    <= 1'b1;
            o_ram_addr  <= xa;
            o_ram_wdata <= xd;
         end
         if (to_flash) begin
            // Any flash attempt consumes the key, whatever the outcome
            key_r <= KEY_LOCKED;
            if (key_r != KEY_OPEN) begin
               blocked_r <= 1'b1;
            end else if (~blocked_r & short_ok) begin
               if (er_en) begin
                  state_r    <= ST_ERAS;
                  cnt_r      <= ERASE_CNT;
                  o_fl_erase <= 1'b1;
                  o_fl_addr  <= page_base(fa);
                  buf_vld_r  <= 1'b0;
               end else if (blk_en & ~buf_vld_r) begin
                  // First of a pair: hold it, no array activity yet
                  buf_vld_r  <= 1'b1;
                  buf_addr_r <= fa;
                  buf_data_r <= xd;
               end else if (blk_en) begin
                  // Pair commits in one program time
                  buf_vld_r  <= 1'b0;
                  state_r    <= ST_PROG;
                  cnt_r      <= PROG_CNT;
                  o_fl_prog  <= 1'b1;
                  o_fl_pair  <= 1'b1;
                  o_fl_addr  <= buf_addr_r;
                  // Array ANDs the data in, so bits only fall
                  o_fl_wdata <= {xd, buf_data_r};
               end else begin
                  state_r    <= ST_PROG;
                  cnt_r      <= PROG_CNT;
                  o_fl_prog  <= 1'b1;
                  o_fl_pair  <= 1'b0;
                  o_fl_addr  <= fa;
                  o_fl_wdata <= {8'hff, xd};
               end
            end
         end
      end
   end

endmodule // fpec_core

// [core/fpec_defines.vh]
`ifndef FPEC_DEFINES_VH
`define FPEC_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FPEC_OFF_CTRL         12'h000
`define FPEC_OFF_KEY          12'h004
`define FPEC_OFF_SCALE        12'h008
`define FPEC_OFF_CACHE        12'h00c
`define FPEC_OFF_STATUS       12'h010
`define FPEC_OFF_XADDR        12'h014
`define FPEC_OFF_XDATA        12'h018

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FPEC_CTRL_WE_BIT      0
`define FPEC_CTRL_EE_BIT      1
`define FPEC_SCALE_WT_BIT     4
`define FPEC_CACHE_BLK_BIT    0
`define FPEC_XADDR_SHORT_BIT  16

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define FPEC_KEY_FIRST        8'ha5
`define FPEC_KEY_SECOND       8'hf1
`define FPEC_ERASED_BYTE      8'hff
`define FPEC_SHORT_ADDR_MAX   16'h00ff
`define FPEC_PAGE_BYTES       512
`define FPEC_CTRL_RST         2'h0
`define FPEC_SCALE_RST        8'h00
`define FPEC_CACHE_RST        8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FPEC_CLK_MHZ          25
`define FPEC_PROG_TIME_US     40
`define FPEC_ERASE_TIME_US    20000

`endif

// [dv/flash_program_erase_control_tb.sv]
`timescale 1ns/1ps
`include "fpec_defines.vh"
`define CK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
   $display("mismatch at %0t got %h exp %h", $time, a, b); end end
module flash_program_erase_control_tb;
   logic        i_clk = 0, i_rst = 1, hsel = 0, hwrite = 0, fp, fe, fpair, rwe, rdy;
   logic        stall, hresp;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [14:0] fa, pa, ea;
   logic [15:0] fd, pd, rad;
   logic [7:0]  frd, rwd;
   int          fails = 0, tests_run = 0, np, ne, nr, ns;
   localparam int PC = 4;
   localparam int EC = 8;
   always #20 i_clk = ~i_clk;
   fpec_core #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(hresp), .o_hrdata(hrdata),
      .o_fl_prog(fp), .o_fl_erase(fe), .o_fl_addr(fa), .o_fl_wdata(fd), .o_fl_pair(fpair),
      .i_fl_rdata(frd), .o_ram_we(rwe), .o_ram_addr(rad), .o_ram_wdata(rwd),
      .o_core_stall(stall));
   fpec_flash_model #(.AW(15)) i_fl (.i_clk(i_clk), .i_prog(fp), .i_erase(fe), .i_pair(fpair),
      .i_addr(fa), .i_wdata(fd), .o_rdata(frd));
   always @(posedge i_clk) begin
      if (fp) begin np++; pa <= fa; pd <= fd; end
      if (fe) begin ne++; ea <= fa; end
      if (rwe) nr++;
      if (stall) ns++;
   end
   task close_out;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hready and read data are taken at the rising edge, before the slave's registers move
   task wt;
      int n;
      n = 0;
      @(posedge i_clk);
      while (!rdy && n < 3000) begin @(posedge i_clk); n++; end
      if (n >= 3000) begin fails++; close_out; end
      rd = hrdata;
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= w; wt;
      hsel <= 0; htrans <= 2'h0; hwdata <= d; wt;
   endtask
   task rst; np = 0; ne = 0; nr = 0; ns = 0; i_rst <= 1; repeat (10) @(posedge i_clk); i_rst <= 0; endtask
   task keys; bus(1, `FPEC_OFF_KEY, `FPEC_KEY_FIRST); bus(1, `FPEC_OFF_KEY, `FPEC_KEY_SECOND); endtask
   task mv(input logic [16:0] a, input logic [7:0] d);
      bus(1, `FPEC_OFF_XADDR, {15'h0, a}); bus(1, `FPEC_OFF_XDATA, {24'h0, d});
      bus(0, `FPEC_OFF_STATUS, 0);
   endtask
   task t_prog;
      rst; bus(1, `FPEC_OFF_CTRL, 1);
      bus(1, `FPEC_OFF_SCALE, 32'h1 << `FPEC_SCALE_WT_BIT); bus(0, `FPEC_OFF_SCALE, 0);
      `CK(rd[`FPEC_SCALE_WT_BIT], 1'b1)
      keys; mv(17'h0123, 8'h3c);
      `CK(np, 1)
      `CK(pd, 16'hff3c)
      `CK(rd[1:0], 2'h0)
      `CK(ns, PC)
      `CK(hresp, 1'b0)
      keys; mv(17'h0123, 8'h0f);
      `CK(i_fl.mem[15'h123], 8'h0c)
      mv(17'h0124, 8'h00);
      `CK(np, 2)
      `CK(rd[3], 1'b1)
      $display("t_prog done");
   endtask
   task t_erase;
      rst; bus(1, `FPEC_OFF_CTRL, 1); keys; mv(17'h03ff, 8'h00);
      bus(1, `FPEC_OFF_CTRL, 3); keys; mv(17'h0345, 8'h00);
      `CK(ne, 1)
      `CK(ns, PC + EC)
      `CK(ea, 15'h200)
      `CK(i_fl.mem[15'h3ff], 8'hff)
      `CK(i_fl.mem[15'h123], 8'h0c)
      $display("t_erase done");
   endtask
   task t_key;
      rst; bus(1, `FPEC_OFF_KEY, `FPEC_KEY_SECOND); bus(0, `FPEC_OFF_STATUS, 0);
      `CK(rd[3], 1'b1)
      bus(1, `FPEC_OFF_CTRL, 1); keys; mv(17'h0050, 8'h00);
      `CK(np, 0)
      $display("t_key done");
   endtask
   task t_ram;
      rst; bus(1, `FPEC_OFF_KEY, `FPEC_KEY_FIRST); mv(17'h0060, 8'h5a);
      `CK(nr, 1)
      `CK(rad, 16'h0060)
      `CK(rwd, 8'h5a)
      `CK(rd[1:0], 2'h1)
      bus(1, `FPEC_OFF_KEY, `FPEC_KEY_SECOND); bus(1, `FPEC_OFF_CTRL, 1); mv(17'h0061, 8'h5a);
      `CK(np, 1)
      bus(0, 12'h040, 0);
      `CK(rd, 32'h0)
      bus(1, `FPEC_OFF_CTRL, 0); mv(17'h0062, 8'h77);
      `CK(nr, 2)
      `CK(np, 1)
      $display("t_ram done");
   endtask
   task t_short;
      rst; bus(1, `FPEC_OFF_CTRL, 1); keys; mv(17'h100ff, 8'hf0);
      `CK(np, 1)
      keys; mv(17'h10100, 8'hf0);
      `CK(np, 1)
      $display("t_short done");
   endtask
   task t_blk;
      rst; bus(1, `FPEC_OFF_CACHE, 1); bus(1, `FPEC_OFF_CTRL, 1); keys; mv(17'h0010, 8'h11);
      `CK(np, 0)
      `CK(rd[4], 1'b1)
      keys; mv(17'h0011, 8'h22);
      `CK(np, 1)
      `CK(pd, 16'h2211)
      `CK(ns, PC)
      `CK(i_fl.mem[15'h011], 8'h22)
      $display("t_blk done");
   endtask
   initial begin
      t_prog; t_erase; t_key; t_ram; t_short; t_blk;
      close_out;
   end
endmodule // flash_program_erase_control_tb

// [dv/fpec_core_asserts.sv]
`timescale 1ns/1ps
module fpec_core_asserts #(
   parameter AW = 15
) (
   input logic          i_clk,
   input logic          i_rst,
   input logic          o_hreadyout,
   input logic          o_fl_prog,
   input logic          o_fl_erase,
   input logic [AW-1:0] o_fl_addr,
   input logic          o_ram_we,
   input logic          o_core_stall
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_prog_stall: assert property (o_fl_prog |=> o_core_stall)
      else $error("no stall after program start");
   a_prog_time: assert property (o_fl_prog |-> ##[1:6] !o_core_stall)
      else $error("program stall too long");
   a_erase_time: assert property (o_fl_erase |=> o_core_stall[*4] ##[1:6] !o_core_stall)
      else $error("erase stall length wrong");
   a_page_base: assert property (o_fl_erase |-> o_fl_addr[8:0] == 9'h000)
      else $error("erase address not page base");
   a_one_op: assert property (!(o_fl_prog && o_fl_erase))
      else $error("program and erase together");
   a_no_retrig: assert property (o_core_stall && $past(o_core_stall) |-> !o_fl_prog && !o_fl_erase)
      else $error("flash started during stall");
   a_wait_op: assert property (!o_hreadyout |-> o_core_stall)
      else $error("wait state without flash operation");
   a_ram_only: assert property (o_ram_we |-> !o_fl_prog && !o_fl_erase && !o_core_stall)
      else $error("ram write mixed with flash");
   a_prog_pulse: assert property (o_fl_prog |=> !o_fl_prog)
      else $error("program pulse longer than one cycle");
   a_ram_pulse: assert property (o_ram_we |=> !o_ram_we)
      else $error("ram write pulse longer than one cycle");
endmodule // fpec_core_asserts

bind fpec_core fpec_core_asserts #(.AW(AW)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
   .o_hreadyout(o_hreadyout), .o_fl_prog(o_fl_prog), .o_fl_erase(o_fl_erase),
   .o_fl_addr(o_fl_addr), .o_ram_we(o_ram_we), .o_core_stall(o_core_stall));

// [dv/fpec_flash_model.sv]
`timescale 1ns/1ps
module fpec_flash_model #(
   parameter AW = 15
) (
   input  logic          i_clk,
   input  logic          i_prog,
   input  logic          i_erase,
   input  logic          i_pair,
   input  logic [AW-1:0] i_addr,
   input  logic [15:0]   i_wdata,
   output logic [7:0]    o_rdata
);
   logic [7:0] mem [0:(1<<AW)-1];
   initial for (int k = 0; k < (1<<AW); k++) mem[k] = 8'hff;
   assign o_rdata = mem[i_addr];
   // Cells only lose charge on program; erase is the only way back to ones
   always @(posedge i_clk) begin
      if (i_prog) begin
         mem[i_addr] <= mem[i_addr] & i_wdata[7:0];
         if (i_pair) mem[i_addr+1] <= mem[i_addr+1] & i_wdata[15:8];
      end
      if (i_erase) for (int k = 0; k < 512; k++) mem[{i_addr[AW-1:9], 9'h000} + k] <= 8'hff;
   end
endmodule // fpec_flash_model
